// file: hw/gs_seq_defs.svh
// Offsets, field positions, reset values and timing counts of the sequencer.
// Assumes an APB slave with 32-bit data and one aligned word per register.
`ifndef GS_SEQ_DEFS_SVH
`define GS_SEQ_DEFS_SVH

// Register byte offsets
`define OFS_CTRL     12'h000
`define OFS_EXPOSURE 12'h004
`define OFS_CYCLE    12'h008
`define OFS_FRAME    12'h00C
`define OFS_IFRAME   12'h010
`define OFS_STATUS   12'h014
`define OFS_DROPPED  12'h018

// Control fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_ACQ_BIT  2

// Reset values
`define RST_EXPOSURE 32'h0000_0500
`define RST_CYCLE    32'h0000_1000
`define RST_FRAME    32'h0000_0438
`define RST_IFRAME   32'h0000_0002

// Timing: one row is a full row readout in sensor clocks
`define ROW_CLOCKS      12'hA40
`define XFER_CLOCKS     12'h010
`define CLEAR_CLOCKS    12'h008
`define NONOVL_MIN_ROWS 32'h0000_0003
`define START_DLY_ROWS  32'h0000_0001

`endif

// file: hw/gs_seq_pkg.sv
// Types shared by the sequencer files.
// Assumes gs_seq_defs.svh is compiled alongside.
package gs_seq_pkg;
  // Triggering mode selected by software
  typedef enum logic [1:0] {
    MODE_EXT_EXP_NONOVL = 2'h0,
    MODE_EXT_EXP_OVL    = 2'h1,
    MODE_EXT_START_OFF  = 2'h2,
    MODE_EXT_START_ON   = 2'h3
  } mode_e;

  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_CLEAR   = 8'h02,
    ST_REF     = 8'h04,
    ST_EXPOSE  = 8'h08,
    ST_XFER    = 8'h10,
    ST_SIG     = 8'h20,
    ST_INTER   = 8'h40,
    ST_WAIT    = 8'h80
  } state_e;
endpackage

// file: hw/trigger_sync.sv
// Synchroniser and edge detector for the external trigger pin.
// Assumes the pin is asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module trigger_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin and detected events
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic stage;
  logic prev;

  // RULE24: two stages, then edges
  // The first stage feeds only the second, so no logic sees a metastable value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta  <= 1'b0;
      stage <= 1'b0;
      prev  <= 1'b0;
    end else begin
      meta  <= pin;
      stage <= meta;
      prev  <= stage;
    end
  end

  assign level = stage;
  assign rise  = stage & ~prev;
  assign fall  = ~stage & prev;
endmodule
`default_nettype wire

// file: hw/gs_trigger_sequencer.sv
// Global shutter trigger sequencer: external exposure and external start modes.
// Assumes an APB master on pclk and an asynchronous trigger pin.
// What this block does
// RULE1: Idle keeps the sensor in a continuous pre-scan readout.
// RULE2: Non-overlap external exposure: trigger pulses clear, exposure follows trigger high.
// RULE3: Non-overlap: reference frame readout starts right at exposure start.
// RULE4: Trigger fall ends exposure by global charge transfer, then signal readout.
// RULE5: A fall before reference readout ends is ignored; wait for a later one.
// RULE6: Trigger source holds high at least one frame plus three rows.
// RULE7: Trigger period at least width plus frame, interframe and six rows.
// RULE8: Overlap: each rise starts signal readout and a new exposure.
// RULE9: Overlap: rise-to-rise interval is exposure and cycle time.
// RULE10: Overlap: first rise starts exposure; its bogus frame is dropped.
// RULE11: Overlap: signal frame then reference frame after each edge.
// RULE12: Overlap: rises during signal or reference readout are ignored.
// RULE13: Ready output high only while a rise would be accepted.
// RULE14: Overlap exposure starts one charge transfer after the edge.
// RULE15: Trigger source holds each trigger high two sensor clocks.
// RULE16: External start waits for one trigger, then runs internally timed.
// RULE17: External start: ready high while the start trigger is detectable.
// RULE18: Start overlap off: short and long exposure ranges allowed.
// RULE19: Start overlap on: exposure from frame plus interframe plus row, delay 1-2 rows.
// RULE20: Exposure writes rejected during acquisition in external exposure modes.
// RULE21: One row is 2624 sensor clocks.
// RULE22: One frame is the configured rows per sensor half.
// RULE23: Exposure is counted in whole rows.
// RULE24: Trigger is synchronised and edge detected.
// RULE25: Counters are 32 bits wide in rows.
`timescale 1ns/1ps
`default_nettype none
`include "gs_seq_defs.svh"
module gs_trigger_sequencer (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger pin
  input  wire logic        external_trigger_input,
  // Sensor controls
  output logic             global_clear,
  output logic             charge_transfer,
  output logic             prescan_read,
  output logic             ref_read,
  output logic             sig_read,
  output logic             frame_valid,
  output logic             ready
);

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  logic [1:0]  mode;
  logic        acq;
  logic [31:0] exposure;
  logic [31:0] cycle;
  logic [31:0] frame_rows;
  logic [31:0] iframe_rows;
  logic [31:0] dropped;
  gs_seq_pkg::state_e state;
  gs_seq_pkg::state_e next_state;
  logic [11:0] clk_cnt;
  logic [31:0] row_cnt;
  logic [31:0] exp_cnt;
  logic [31:0] cyc_cnt;
  logic        started;
  logic        first_done;
  logic        trig_rise;
  logic        trig_fall;

  // Trigger pin passes two flops before any decode reads it
  // Level is left open: only the edges steer the sequence
  trigger_sync u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .pin   (external_trigger_input),
    .level (),
    .rise  (trig_rise),
    .fall  (trig_fall)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Saturating increment keeps long exposures from wrapping
  function automatic logic [31:0] inc_sat(input logic [31:0] v);
    inc_sat = (v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001;
  endfunction

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire access   = psel & penable;
  wire wr_en    = access & pwrite;
  wire hit_ctrl = (paddr == `OFS_CTRL);
  wire hit_exp  = (paddr == `OFS_EXPOSURE);
  wire hit_cyc  = (paddr == `OFS_CYCLE);
  wire hit_frm  = (paddr == `OFS_FRAME);
  wire hit_ifr  = (paddr == `OFS_IFRAME);
  wire hit_sts  = (paddr == `OFS_STATUS);
  wire hit_drp  = (paddr == `OFS_DROPPED);
  wire mapped   = hit_ctrl | hit_exp | hit_cyc | hit_frm | hit_ifr | hit_sts | hit_drp;
  wire ext_exp  = (mode == gs_seq_pkg::MODE_EXT_EXP_NONOVL) |
                  (mode == gs_seq_pkg::MODE_EXT_EXP_OVL);
  // RULE20: lock exposure in external exposure
  wire exp_lock = acq & ext_exp;
  // Errored writes are answered with pslverr and store nothing
  wire wr_err   = wr_en & (~mapped | hit_sts | hit_drp | (hit_exp & exp_lock));
  wire [31:0] status_word = {20'h0_0000, ready, started, first_done, acq, state};
  // Read mux; unmapped offsets read as zero
  wire [31:0] rd_word =
    hit_ctrl ? {29'h0000_0000, acq, mode} :
    hit_exp  ? exposure :
    hit_cyc  ? cycle :
    hit_frm  ? frame_rows :
    hit_ifr  ? iframe_rows :
    hit_sts  ? status_word :
    hit_drp  ? dropped : 32'h0000_0000;

  // Zero-wait-state APB answer: pready rises the cycle after setup
  // Read data is captured in the setup cycle so it stands with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_word : prdata;
      pslverr <= psel & ~penable & (~mapped | (pwrite & (hit_sts | hit_drp |
                 (hit_exp & exp_lock))));
    end
  end

  // Register writes take effect at the access edge with pready high
  wire wr_take = wr_en & pready & ~wr_err;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode        <= 2'h0;
      acq         <= 1'b0;
      exposure    <= `RST_EXPOSURE;
      cycle       <= `RST_CYCLE;
      frame_rows  <= `RST_FRAME;
      iframe_rows <= `RST_IFRAME;
    end else if (wr_take) begin
      // Limitation: new exposure and cycle values apply at the next compare
      if (hit_ctrl) begin
        // Mode is frozen while acquiring so a running sequence keeps its shape
        mode <= acq ? mode : pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
        acq  <= pwdata[`CTRL_ACQ_BIT];
      end
      // RULE23: exposure held in rows
      if (hit_exp) exposure <= (pwdata == 32'h0) ? 32'h0000_0001 : pwdata;
      if (hit_cyc) cycle <= pwdata;
      // RULE22: frame rows from region size
      if (hit_frm) frame_rows <= (pwdata == 32'h0) ? 32'h0000_0001 : pwdata;
      if (hit_ifr) iframe_rows <= pwdata;
    end
  end

  // ------------------------------------------------------------
  // Row timebase
  // ------------------------------------------------------------
  // The row counter restarts on every state change, so each state
  // measures its own length from its entry, in whole rows, or in clocks in CLEAR and XFER
  // RULE21: row tick every 2624 clocks
  wire row_tick = (clk_cnt == `ROW_CLOCKS - 12'h001);
  wire frame_done = row_tick & (row_cnt + 32'h1 >= frame_rows);
  wire ifr_done   = row_tick & (row_cnt + 32'h1 >= iframe_rows);
  wire xfer_done  = (clk_cnt == `XFER_CLOCKS - 12'h001);
  wire clear_done = (clk_cnt == `CLEAR_CLOCKS - 12'h001);
  wire is_ovl_exp = (mode == gs_seq_pkg::MODE_EXT_EXP_OVL);
  wire is_start   = ~ext_exp;
  // RULE18: short exposure fits within reference read
  wire short_exp  = (mode == gs_seq_pkg::MODE_EXT_START_OFF) &
                    (exposure <= frame_rows + `NONOVL_MIN_ROWS);
  // Internal timing for start modes: end exposure once counted rows reach target
  wire exp_reached = (exp_cnt >= exposure);
  // RULE19: overlap-on start needs frame plus interframe plus row
  wire ovl_min_ok  = exp_cnt >= frame_rows + iframe_rows + 32'h1;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  // One state per readout phase; readout lengths come from the row counters
  // Triggers are only looked at in IDLE and EXPOSE, so ignored edges do no harm
  always_comb begin
    next_state = state;
    unique case (state)
      gs_seq_pkg::ST_IDLE: begin
        // RULE1: pre-scan while waiting
        // RULE16: one start trigger only
        if (acq & trig_rise & (ext_exp | ~started)) begin
          // RULE14: overlap edges go straight to charge transfer
          // Start modes spend one row in WAIT before the clear
          if (is_ovl_exp) next_state = gs_seq_pkg::ST_XFER;
          else if (is_start) next_state = gs_seq_pkg::ST_WAIT;
          else next_state = gs_seq_pkg::ST_CLEAR;
        end
      end
      gs_seq_pkg::ST_WAIT: begin
        // RULE19: start delay of one row
        if (!acq) next_state = gs_seq_pkg::ST_IDLE;
        else if (row_tick) next_state = gs_seq_pkg::ST_CLEAR;
      end
      gs_seq_pkg::ST_CLEAR: begin
        // RULE2: clear pulse opens exposure
        if (clear_done) next_state = gs_seq_pkg::ST_REF;
      end
      gs_seq_pkg::ST_REF: begin
        // RULE3: reference read during exposure
        if (frame_done) next_state = gs_seq_pkg::ST_EXPOSE;
      end
      gs_seq_pkg::ST_EXPOSE: begin
        // RULE5: fall only counts after reference read
        // RULE4: fall ends exposure
        if (!acq) next_state = gs_seq_pkg::ST_IDLE;
        else if (mode == gs_seq_pkg::MODE_EXT_EXP_NONOVL) begin
          if (trig_fall) next_state = gs_seq_pkg::ST_XFER;
        end else if (is_ovl_exp) begin
          // RULE8: rise ends exposure and starts next
          if (trig_rise) next_state = gs_seq_pkg::ST_XFER;
        end else if (exp_reached &
                     ((mode != gs_seq_pkg::MODE_EXT_START_ON) | ovl_min_ok)) begin
          next_state = gs_seq_pkg::ST_XFER;
        end
      end
      gs_seq_pkg::ST_XFER: begin
        if (xfer_done) next_state = gs_seq_pkg::ST_SIG;
      end
      gs_seq_pkg::ST_SIG: begin
        // RULE11: signal frame before next reference
        if (frame_done) next_state = gs_seq_pkg::ST_INTER;
      end
      // Interframe gap, then the next cycle or back to idle
      gs_seq_pkg::ST_INTER: begin
        if (!ifr_done) next_state = gs_seq_pkg::ST_INTER;
        else if (!acq) next_state = gs_seq_pkg::ST_IDLE;
        else if (is_ovl_exp) next_state = gs_seq_pkg::ST_REF;
        else if (is_start & (cyc_cnt >= cycle)) next_state = gs_seq_pkg::ST_CLEAR;
        else if (is_start) next_state = gs_seq_pkg::ST_INTER;
        else next_state = gs_seq_pkg::ST_IDLE;
      end
      default: next_state = gs_seq_pkg::ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // State, timebase and row counters
  // ------------------------------------------------------------
  wire state_change = (next_state != state);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= gs_seq_pkg::ST_IDLE;
      clk_cnt <= 12'h000;
      row_cnt <= 32'h0000_0000;
    end else begin
      state   <= next_state;
      clk_cnt <= (state_change | row_tick) ? 12'h000 : clk_cnt + 12'h001;
      row_cnt <= state_change ? 32'h0000_0000 : (row_tick ? row_cnt + 32'h1 : row_cnt);
    end
  end

  // Saturation keeps a very long exposure from wrapping to a short one
  // RULE25: 32-bit exposure and cycle counts
  // RULE9: exposure measured from clear, or in overlap from the previous transfer, to transfer
  wire exp_restart = (state == gs_seq_pkg::ST_CLEAR) |
                     ((state == gs_seq_pkg::ST_XFER) & is_ovl_exp);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_cnt <= 32'h0000_0000;
      cyc_cnt <= 32'h0000_0000;
    end else begin
      exp_cnt <= exp_restart ? 32'h0000_0000 : (row_tick ? inc_sat(exp_cnt) : exp_cnt);
      cyc_cnt <= (state == gs_seq_pkg::ST_CLEAR) ? 32'h0000_0000 :
                 (row_tick ? inc_sat(cyc_cnt) : cyc_cnt);
    end
  end

  // ------------------------------------------------------------
  // Acquisition bookkeeping
  // ------------------------------------------------------------
  // Started blocks a second start trigger; first_done marks the dropped frame
  // Both clear with acq so a new acquisition drops its first overlap frame again
  // RULE10: first overlap frame is discarded
  wire sig_end = (state == gs_seq_pkg::ST_SIG) & frame_done;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started    <= 1'b0;
      first_done <= 1'b0;
      dropped    <= 32'h0000_0000;
    end else if (!acq) begin
      started    <= 1'b0;
      first_done <= 1'b0;
    end else begin
      started    <= started | (trig_rise & (state == gs_seq_pkg::ST_IDLE));
      first_done <= first_done | sig_end;
      dropped    <= (sig_end & is_ovl_exp & ~first_done) ? inc_sat(dropped) : dropped;
    end
  end

  // ------------------------------------------------------------
  // Sensor and ready outputs, all registered
  // ------------------------------------------------------------
  // Outputs decode next_state so they line up with the state register
  // Ready is registered too, so it changes with the state it describes
  // RULE12: rises during readout not accepted
  // RULE13: ready tracks edge acceptance
  // RULE17: ready while start is detectable
  wire next_ready =
    acq & (ext_exp ? ((next_state == gs_seq_pkg::ST_IDLE) |
                      (is_ovl_exp & (next_state == gs_seq_pkg::ST_EXPOSE)))
                   : ((next_state == gs_seq_pkg::ST_IDLE) & ~started));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_clear    <= 1'b0;
      charge_transfer <= 1'b0;
      prescan_read    <= 1'b1;
      ref_read        <= 1'b0;
      sig_read        <= 1'b0;
      frame_valid     <= 1'b0;
      ready           <= 1'b0;
    end else begin
      global_clear    <= (next_state == gs_seq_pkg::ST_CLEAR) |
                         (is_ovl_exp & (next_state == gs_seq_pkg::ST_XFER) & ~first_done &
                          (state == gs_seq_pkg::ST_IDLE));
      charge_transfer <= (next_state == gs_seq_pkg::ST_XFER);
      prescan_read    <= (next_state == gs_seq_pkg::ST_IDLE) |
                         (next_state == gs_seq_pkg::ST_WAIT);
      ref_read        <= (next_state == gs_seq_pkg::ST_REF) |
                         ((next_state == gs_seq_pkg::ST_EXPOSE) & short_exp);
      sig_read        <= (next_state == gs_seq_pkg::ST_SIG);
      frame_valid     <= (next_state == gs_seq_pkg::ST_SIG) & ~(is_ovl_exp & ~first_done);
      ready           <= next_ready;
    end
  end

endmodule
`default_nettype wire

// file: verif/gs_trigger_sequencer_monitor.sv
// Port-level checker for the trigger sequencer.
// Assumes binding into gs_trigger_sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "gs_seq_defs.svh"
module gs_trigger_sequencer_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Sensor and trigger status
  input wire logic charge_transfer,
  input wire logic prescan_read,
  input wire logic ref_read,
  input wire logic sig_read,
  input wire logic frame_valid,
  input wire logic ready
);
  // ----------------------------------------
  // Clocking and helper counters
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [11:0] xfer_run;

  // Length of the current transfer pulse; a run of 16 is the expected width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) xfer_run <= 12'h000;
    else if (charge_transfer) xfer_run <= xfer_run + 12'h001;
    else xfer_run <= 12'h000;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("APB access phase without pready");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_err_qual: assert property (pslverr |-> pready)
    else $error("pslverr outside a completing access");
  chk_xfer_width: assert property ($fell(charge_transfer) |-> xfer_run == `XFER_CLOCKS)
    else $error("Charge transfer pulse has wrong length");
  chk_xfer_sig: assert property ($fell(charge_transfer) |-> ##[0:4] sig_read)
    else $error("Signal readout missing after transfer");
  chk_read_excl: assert property (!(sig_read && ref_read))
    else $error("Signal and reference readout overlap");
  chk_prescan_quiet: assert property (prescan_read |-> !(ref_read || sig_read || charge_transfer))
    else $error("Pre-scan while a frame is active");
  chk_valid_sig: assert property (frame_valid |-> sig_read)
    else $error("Frame valid outside signal readout");
  chk_busy_ready: assert property ((sig_read || ref_read) |-> !ready)
    else $error("Ready high during a readout");
endmodule
bind gs_trigger_sequencer gs_trigger_sequencer_monitor gs_trigger_sequencer_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .charge_transfer(charge_transfer), .prescan_read(prescan_read),
  .ref_read(ref_read), .sig_read(sig_read), .frame_valid(frame_valid), .ready(ready));
`default_nettype wire

// file: verif/trigger_source_model.sv
// Model of the external trigger source.
// Assumes fire is a one-cycle request on pclk.
`timescale 1ns/1ps
`default_nettype none
module trigger_source_model (
  // Clock and request
  input wire logic        pclk,
  input wire logic        fire,
  input wire logic [31:0] width,
  // Trigger pin
  output var logic        trig
);
  logic [31:0] left;
  initial begin
    trig = 1'b0;
    left = 32'h0;
  end

  // pulse width: held high for width clocks; the callers here pass two or more
  // width and period are chosen by the caller per scenario
  always @(posedge pclk) begin
    if (fire) begin
      trig <= 1'b1;
      left <= width - 32'h1;
    end else if (left != 32'h0) begin
      left <= left - 32'h1;
    end else begin
      trig <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verif/tb_gs_trigger_sequencer.sv
// Self-checking bench for the trigger sequencer.
// Assumes the monitor is bound and defines come from gs_seq_defs.svh.
`timescale 1ns/1ps
`default_nettype none
`include "gs_seq_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
`define WAITQ(c, lim) begin n = 0; while (!(c) && n < (lim)) begin \
  @(posedge pclk); n++; end end
module tb_gs_trigger_sequencer;
  localparam int ROW = `ROW_CLOCKS;
  logic pclk, presetn, psel, penable, pwrite, trig, fire, pready, pslverr, err;
  logic global_clear, charge_transfer, prescan_read, ref_read, sig_read, frame_valid, ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, width;
  int miscompares, tests_run, n;

  // ----------------------------------------
  // Clock, reset, instances
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, fire} = 5'h00;
    paddr = 12'h000; pwdata = 32'h0; width = 32'h2;
    miscompares = 0; tests_run = 0;
  end
  gs_trigger_sequencer gs_trigger_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_trigger_input(trig),
    .global_clear(global_clear), .charge_transfer(charge_transfer),
    .prescan_read(prescan_read), .ref_read(ref_read), .sig_read(sig_read),
    .frame_valid(frame_valid), .ready(ready));
  trigger_source_model trigger_source_model_i (.pclk(pclk), .fire(fire), .width(width),
    .trig(trig));

  // ----------------------------------------
  // Bus and trigger tasks
  // ----------------------------------------
  // One APB transfer; waits for pready as long as it takes, the watchdog ends a hang
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rdata = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task pulse(input logic [31:0] w);
    fire <= 1'b1; width <= w;
    @(posedge pclk);
    fire <= 1'b0;
  endtask
  task report_and_stop;
    $display("Counts: %0d compared, %0d mismatched", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    apb(0, `OFS_FRAME, 0); `CHK(rdata, `RST_FRAME)
    apb(0, `OFS_IFRAME, 0); `CHK(rdata, `RST_IFRAME)
    apb(1, `OFS_CYCLE, 32'hFFFF_FFFF); apb(0, `OFS_CYCLE, 0); `CHK(rdata, 32'hFFFF_FFFF)
    apb(1, `OFS_EXPOSURE, 32'h8000_0000); apb(0, `OFS_EXPOSURE, 0); `CHK(rdata, 32'h8000_0000)
    apb(1, `OFS_EXPOSURE, 0); apb(0, `OFS_EXPOSURE, 0); `CHK(rdata, 32'h1)
    apb(1, `OFS_STATUS, 0); `CHK(err, 1'b1)
    apb(1, 12'h01C, 0); `CHK(err, 1'b1)
    apb(1, `OFS_FRAME, 32'h2); apb(1, `OFS_IFRAME, 32'h1); `CHK(err, 1'b0)
    `CHK(prescan_read, 1'b1)
    $display("test regs done");
  endtask
  // Short pulse first: its fall lands inside the reference frame
  task t_nonovl;
    apb(1, `OFS_CTRL, 32'h4); apb(1, `OFS_EXPOSURE, 32'h9); `CHK(err, 1'b1)
    pulse(100); `WAITQ(global_clear, 20) `CHK(global_clear, 1'b1)
    `WAITQ(ref_read, 40) `CHK(ref_read, 1'b1)
    repeat (300) @(posedge pclk); `CHK({ref_read, sig_read}, 2'b10)
    `WAITQ(!ref_read, 6000) pulse(50); `WAITQ(charge_transfer, 90) `CHK(charge_transfer, 1'b1)
    `WAITQ(sig_read, 40) `CHK(frame_valid, 1'b1)
    `WAITQ(prescan_read, 9000) `CHK(prescan_read, 1'b1)
    apb(1, `OFS_CTRL, 32'h0);
    $display("test non-overlap done");
  endtask
  task t_ovl;
    apb(1, `OFS_CTRL, 32'h5); repeat (2) @(posedge pclk); `CHK(ready, 1'b1)
    pulse(2); `WAITQ(charge_transfer, 10) `CHK(charge_transfer, 1'b1)
    `WAITQ(sig_read, 30) `CHK(frame_valid, 1'b0)
    `CHK(ready, 1'b0)
    pulse(2); `WAITQ(ref_read, 9000) `CHK(n >= 2 * ROW, 1'b1)
    `WAITQ(ready, 9000) `CHK(ready, 1'b1)
    pulse(2); `WAITQ(charge_transfer, 10) `CHK(charge_transfer, 1'b1)
    `WAITQ(frame_valid, 30) `CHK(frame_valid, 1'b1)
    apb(0, `OFS_DROPPED, 0); `CHK(rdata, 32'h1)
    `WAITQ(ready, 14000) `CHK(ready, 1'b1)
    apb(1, `OFS_CTRL, 32'h0); `WAITQ(prescan_read, 9000) `CHK(prescan_read, 1'b1)
    $display("test overlap done");
  endtask
  // Both start modes: one trigger, delayed start, ready low once started
  task t_start(input logic [31:0] ctrl);
    apb(1, `OFS_FRAME, 32'h1); apb(1, `OFS_CYCLE, 32'h6); apb(1, `OFS_CTRL, ctrl);
    apb(1, `OFS_EXPOSURE, 32'h1); `CHK(err, 1'b0)
    `CHK(ready, 1'b1)
    pulse(2); `WAITQ(global_clear || ref_read, 3 * ROW)
    `CHK(n >= ROW - 8 && n <= 2 * ROW, 1'b1)
    `CHK(ready, 1'b0)
    apb(1, `OFS_CTRL, 32'h0); `WAITQ(prescan_read, 3 * ROW)
    `CHK(prescan_read, 1'b1)
    $display("test start mode done");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs; t_nonovl; t_ovl;
    t_start(32'h6); t_start(32'h7);
    report_and_stop;
  end
  initial begin
    repeat (80000) @(posedge pclk);
    miscompares++;
    report_and_stop;
  end
endmodule
`default_nettype wire
